/* hw/bcmc_top.v */
// Bus clock mode control: clock selection, wait handling, register slave
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`include "bcmc_defs.vh"

module bcmc_top #(
  parameter ACC_BEATS = 1,
  parameter CNT_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire bus_clock_i,
  input wire fast_core_clock_i,
  input wire bus_stall_n_i,
  input wire single_clock_sel_i,
  input wire sync_async_select_i,
  input wire addr_timing_sel_i,
  input wire acc_req_i,
  input wire acc_read_i,
  input wire acc_buffered_i,
  output wire acc_ready_o,
  output wire acc_done_o,
  output wire core_tick_o,
  output wire core_stall_o,
  output wire bus_tick_o,
  output wire mem_req_n_o,
  output wire core_on_bus_o,
  output wire delayed_addr_o,
  output wire addr_latch_o
);

  wire [`BCMC_NPINS-1:0] pin_lvl;
  wire [`BCMC_NPINS-1:0] pin_rise;

  bcmc_pin_sync #(
    .W(`BCMC_NPINS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({addr_timing_sel_i, sync_async_select_i, single_clock_sel_i,
            bus_stall_n_i, fast_core_clock_i, bus_clock_i}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise)
  );

  wire bclk_rise = pin_rise[`BCMC_P_BCLK];
  wire fast_core_clock_rise = pin_rise[`BCMC_P_FAST_CORE_CLOCK];
  wire stall_n = pin_lvl[`BCMC_P_STALL];
  wire single = pin_lvl[`BCMC_P_SINGLE];
  wire sync_mode = pin_lvl[`BCMC_P_SYNC] & ~single;
  wire ale = pin_lvl[`BCMC_P_ALE];

  wire bus_edge = bclk_rise & stall_n;

  reg [1:0] ctrl_ff;
  reg [1:0] nxt_ctrl;
  reg [1:0] src_ff;
  reg [1:0] nxt_src;
  reg acc_ff;
  reg nxt_acc;
  reg acc_read_ff;
  reg nxt_acc_read;
  reg acc_buf_ff;
  reg nxt_acc_buf;
  reg [7:0] beat_ff;
  reg [7:0] nxt_beat;
  reg [CNT_W-1:0] wcnt_ff;
  reg [CNT_W-1:0] nxt_wcnt;
  reg done_ff;
  reg nxt_done;
  reg core_tick_ff;
  reg nxt_core_tick;
  reg bus_tick_ff;
  reg mreq_n_ff;
  reg nxt_mreq_n;
  reg stall_ff;
  reg on_bus_ff;
  reg delayed_ff;
  reg latch_ff;
  reg ready_ff;
  reg ack_ff;
  reg nxt_ack;
  reg [31:0] rdat_ff;
  reg [31:0] nxt_rdat;

  wire fast_en = ctrl_ff[`BCMC_CTRL_FAST_EN];
  wire acc_stalls = acc_ff & ~acc_buf_ff;
  // single mode pins core to bus clock
  wire want_bus = single | ~fast_en | acc_stalls;

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // Writes land at the edge where the master sees ack
  wire wb_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i;

  // Write strobe for one byte of a register
  function lane_wr;
    input [3:0] adr;
    input [3:0] want;
    input [3:0] sel;
    begin
      lane_wr = (adr == want) & sel[0];
    end
  endfunction

  wire ctrl_wr = wb_wr & lane_wr(wb_adr_i, `BCMC_ADR_CTRL, wb_sel_i);
  wire wclr = ctrl_wr & wb_dat_i[`BCMC_CTRL_WCLR];

  // Core clock source selection
  always @* begin
    nxt_src = src_ff;
    case (src_ff)
      `BCMC_SRC_FAST: begin
        if (want_bus) begin
          if (sync_mode | single) begin
            nxt_src = `BCMC_SRC_BUS;
          end else begin
            nxt_src = `BCMC_SRC_TOBUS;
          end
        end
      end
      `BCMC_SRC_TOBUS: begin
        // wait at most one bus period
        if (bclk_rise | single) begin
          nxt_src = `BCMC_SRC_BUS;
        end
      end
      `BCMC_SRC_BUS: begin
        if (!want_bus) begin
          if (sync_mode) begin
            nxt_src = `BCMC_SRC_FAST;
          end else begin
            nxt_src = `BCMC_SRC_TOFAST;
          end
        end
      end
      `BCMC_SRC_TOFAST: begin
        // wait at most one fast period
        if (single) begin
          nxt_src = `BCMC_SRC_BUS;
        end else if (fast_core_clock_rise) begin
          nxt_src = `BCMC_SRC_FAST;
        end else if (want_bus) begin
          nxt_src = `BCMC_SRC_TOBUS;
        end
      end
      default: begin
        nxt_src = `BCMC_SRC_BUS;
      end
    endcase
  end

  // Core tick from the selected clock
  always @* begin
    nxt_core_tick = 1'b0;
    if (single) begin
      nxt_core_tick = bclk_rise;
    end else begin
      case (src_ff)
        `BCMC_SRC_FAST: nxt_core_tick = fast_core_clock_rise & ~want_bus;
        `BCMC_SRC_BUS: nxt_core_tick = bclk_rise;
        `BCMC_SRC_TOBUS: nxt_core_tick = bclk_rise;
        `BCMC_SRC_TOFAST: nxt_core_tick = fast_core_clock_rise;
        default: nxt_core_tick = 1'b0;
      endcase
    end
  end

  // External access sequencing
  always @* begin
    nxt_acc = acc_ff;
    nxt_acc_read = acc_read_ff;
    nxt_acc_buf = acc_buf_ff;
    nxt_beat = beat_ff;
    nxt_wcnt = wcnt_ff;
    nxt_done = 1'b0;
    if (wclr) begin
      nxt_wcnt = {CNT_W{1'b0}};
    end
    case (acc_ff)
      `BCMC_ACC_IDLE: begin
        if (acc_req_i) begin
          nxt_acc = `BCMC_ACC_RUN;
          nxt_acc_read = acc_read_i;
          nxt_acc_buf = acc_buffered_i & ~acc_read_i;
          nxt_beat = 8'h00;
        end
      end
      `BCMC_ACC_RUN: begin
        if (bclk_rise & ~stall_n & ~wclr) begin
          nxt_wcnt = wcnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (bus_edge) begin
          if (beat_ff == ACC_BEATS[7:0] - 8'h01) begin
            nxt_acc = `BCMC_ACC_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_beat = beat_ff + 8'h01;
          end
        end
      end
      default: begin
        nxt_acc = `BCMC_ACC_IDLE;
      end
    endcase
  end

  // request stage opens when an access is accepted, then moves on bus cycles
  always @* begin
    nxt_mreq_n = mreq_n_ff;
    if (!acc_ff & acc_req_i) begin
      nxt_mreq_n = 1'b0;
    end else if (bus_edge) begin
      nxt_mreq_n = ~(acc_ff & ~nxt_done);
    end
  end

  // Register slave
  always @* begin
    nxt_ack = wb_req;
    nxt_ctrl = ctrl_ff;
    nxt_rdat = 32'h00000000;
    if (ctrl_wr) begin
      nxt_ctrl[`BCMC_CTRL_FAST_EN] = wb_dat_i[`BCMC_CTRL_FAST_EN];
    end
    if (wb_req & ~wb_we_i) begin
      case (wb_adr_i)
        `BCMC_ADR_CTRL: nxt_rdat[1:0] = {1'b0, ctrl_ff[`BCMC_CTRL_FAST_EN]};
        `BCMC_ADR_STATUS: begin
          nxt_rdat[`BCMC_ST_SINGLE] = single;
          nxt_rdat[`BCMC_ST_SYNC] = sync_mode;
          nxt_rdat[`BCMC_ST_ON_BUS] = on_bus_ff;
          nxt_rdat[`BCMC_ST_STALL] = stall_ff;
          nxt_rdat[`BCMC_ST_BUSY] = acc_ff;
          nxt_rdat[`BCMC_ST_DELAYED] = delayed_ff;
          nxt_rdat[`BCMC_ST_SWITCHING] = src_ff[1];
        end
        `BCMC_ADR_WAITCNT: nxt_rdat[CNT_W-1:0] = wcnt_ff;
        default: nxt_rdat = 32'h00000000;
      endcase
    end
  end

  // no timeouts, state only moves on edges
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `BCMC_CTRL_RST;
      src_ff <= `BCMC_SRC_BUS;
      acc_ff <= `BCMC_ACC_IDLE;
      acc_read_ff <= 1'b0;
      acc_buf_ff <= 1'b0;
      beat_ff <= 8'h00;
      wcnt_ff <= {CNT_W{1'b0}};
      done_ff <= 1'b0;
      core_tick_ff <= 1'b0;
      bus_tick_ff <= 1'b0;
      mreq_n_ff <= 1'b1;
      stall_ff <= 1'b0;
      on_bus_ff <= 1'b1;
      delayed_ff <= 1'b0;
      latch_ff <= 1'b0;
      ready_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      src_ff <= nxt_src;
      acc_ff <= nxt_acc;
      acc_read_ff <= nxt_acc_read;
      acc_buf_ff <= nxt_acc_buf;
      beat_ff <= nxt_beat;
      wcnt_ff <= nxt_wcnt;
      done_ff <= nxt_done;
      core_tick_ff <= nxt_core_tick;
      bus_tick_ff <= bus_edge;
      mreq_n_ff <= nxt_mreq_n;
      stall_ff <= nxt_acc & ~nxt_acc_buf;
      on_bus_ff <= nxt_src == `BCMC_SRC_BUS;
      delayed_ff <= single & ~ale;
      latch_ff <= ~single & ale;
      ready_ff <= ~nxt_acc;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign acc_ready_o = ready_ff;
  assign acc_done_o = done_ff;
  assign core_tick_o = core_tick_ff;
  assign core_stall_o = stall_ff;
  assign bus_tick_o = bus_tick_ff;
  assign mem_req_n_o = mreq_n_ff;
  assign core_on_bus_o = on_bus_ff;
  assign delayed_addr_o = delayed_ff;
  assign addr_latch_o = latch_ff;

endmodule // bcmc_top

/* hw/bcmc_defs.vh */
// Constants for the bus clock mode control block
`ifndef BCMC_DEFS_VH
`define BCMC_DEFS_VH

// Register byte offsets
`define BCMC_ADR_CTRL 4'h0
`define BCMC_ADR_STATUS 4'h4
`define BCMC_ADR_WAITCNT 4'h8

// Control register fields and reset value
`define BCMC_CTRL_FAST_EN 0
`define BCMC_CTRL_WCLR 1
`define BCMC_CTRL_RST 2'h1

// Status register fields
`define BCMC_ST_SINGLE 0
`define BCMC_ST_SYNC 1
`define BCMC_ST_ON_BUS 2
`define BCMC_ST_STALL 3
`define BCMC_ST_BUSY 4
`define BCMC_ST_DELAYED 5
`define BCMC_ST_SWITCHING 6

// Synchronised pin positions
`define BCMC_P_BCLK 0
`define BCMC_P_FAST_CORE_CLOCK 1
`define BCMC_P_STALL 2
`define BCMC_P_SINGLE 3
`define BCMC_P_SYNC 4
`define BCMC_P_ALE 5
`define BCMC_NPINS 6

// Core clock source states
`define BCMC_SRC_FAST 2'h0
`define BCMC_SRC_BUS 2'h1
`define BCMC_SRC_TOBUS 2'h2
`define BCMC_SRC_TOFAST 2'h3

// Access states
`define BCMC_ACC_IDLE 1'h0
`define BCMC_ACC_RUN 1'h1

`endif

/* hw/bcmc_pin_sync.v */
// Two-stage pin synchroniser with rising edge detection
module bcmc_pin_sync #(
  parameter W = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] lvl_o,
  output wire [W-1:0] rise_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
      prev_ff <= {W{1'b0}};
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign lvl_o = sync_ff;
  assign rise_o = sync_ff & ~prev_ff;

endmodule // bcmc_pin_sync

/* test/bcmc_checker_assertions.sv */
// Port checks for the bus clock mode control block
module bcmc_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire bus_clock_i,
  input wire bus_stall_n_i,
  input wire single_clock_sel_i,
  input wire addr_timing_sel_i,
  input wire acc_req_i,
  input wire acc_read_i,
  input wire acc_buffered_i,
  input wire acc_ready_o,
  input wire acc_done_o,
  input wire core_tick_o,
  input wire core_stall_o,
  input wire bus_tick_o,
  input wire mem_req_n_o,
  input wire delayed_addr_o,
  input wire addr_latch_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode_ff;
  logic [2:0] calm_ff;
  wire in_single = single_clock_sel_i && calm_ff == 3'h7;
  // Mode settled for seven cycles
  always @(posedge clk_i) begin
    mode_ff <= single_clock_sel_i;
    if (rst_i || single_clock_sel_i != mode_ff)
      calm_ff <= 3'h0;
    else if (calm_ff != 3'h7)
      calm_ff <= calm_ff + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s;
    acc_req_i && acc_ready_o;
  endsequence
  sequence stalling_s;
    taken_s ##0 (acc_read_i || !acc_buffered_i);
  endsequence
  ack_single_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  single_tick_a: assert property (
    in_single && $rose(bus_clock_i) |-> ##[2:4] core_tick_o)
    else $error("bus edge gave no core tick");
  fast_ignored_a: assert property (
    in_single && core_tick_o |-> $past(bus_clock_i, 3))
    else $error("core tick without bus edge");
  qualified_tick_a: assert property (
    bus_tick_o |-> $past(bus_stall_n_i, 3) && $past(bus_clock_i, 3))
    else $error("bus tick while wait low");
  read_stall_a: assert property (stalling_s |=> core_stall_o)
    else $error("access did not stall core");
  buffered_run_a: assert property (
    taken_s ##0 (!acc_read_i && acc_buffered_i) |=> !core_stall_o [*2])
    else $error("buffered write stalled core");
  stall_until_done_a: assert property (
    $fell(core_stall_o) |-> acc_done_o) else $error("stall ended early");
  delayed_timing_a: assert property (
    (in_single && !addr_timing_sel_i) [*4] |-> delayed_addr_o)
    else $error("delayed timing not chosen");
  conventional_a: assert property (
    addr_timing_sel_i [*4] |-> !delayed_addr_o)
    else $error("conventional timing not chosen");
  req_ends_done_a: assert property (
    $rose(mem_req_n_o) |-> acc_done_o) else $error("request end");
  req_starts_a: assert property (
    $fell(mem_req_n_o) |-> $past(acc_req_i && acc_ready_o))
    else $error("request start without accepted access");
  done_ready_a: assert property (
    acc_done_o |-> acc_ready_o) else $error("not ready after done");
  latch_single_a: assert property (
    in_single |-> !addr_latch_o) else $error("latch driven in single mode");
endmodule // bcmc_checker

bind bcmc_top bcmc_checker bcmc_checker_inst (.*);

/* test/bcmc_mem_model.sv */
// Memory controller model driving both clocks and wait
module bcmc_mem_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] waits_i,
  output wire logic bus_clock_o,
  output wire logic fast_core_clock_o,
  output wire logic bus_stall_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ph_ff = 4'h0;
  logic [3:0] left_ff = 4'h0;
  logic stall_n_ff = 1'b1;
  assign fast_core_clock_o = ph_ff[2];
  assign bus_clock_o = ph_ff[3];
  assign bus_stall_n_o = stall_n_ff;
  always @(posedge clk_i) begin
    ph_ff <= ph_ff + 4'h1;
    if (ph_ff == 4'h0) begin
      stall_n_ff <= left_ff == 4'h0;
      left_ff <= left_ff - {3'h0, left_ff != 4'h0};
    end
    if (go_i)
      left_ff <= waits_i;
  end
endmodule // bcmc_mem_model

/* test/bus_clock_mode_control_test.sv */
// Self-checking bench for the bus clock mode control block
`include "bcmc_defs.vh"
module bus_clock_mode_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, bus_clock_i, fast_core_clock_i, bus_stall_n_i;
  logic single_clock_sel_i = 1'b1;
  logic sync_async_select_i = 1'b0;
  logic addr_timing_sel_i = 1'b0;
  logic acc_req_i = 1'b0, acc_read_i = 1'b0, acc_buffered_i = 1'b0;
  wire acc_ready_o, acc_done_o, core_tick_o, core_stall_o, bus_tick_o;
  wire mem_req_n_o, core_on_bus_o, delayed_addr_o, addr_latch_o;
  logic go = 1'b0;
  logic [3:0] waits = 4'h0;
  logic [31:0] r;
  logic [31:0] exp_q[$], msk_q[$];
  int error_cnt = 0, checked = 0, cycles = 0, seed = 32'hc6be, wsum = 0;
  bcmc_top bcmc_top_inst (.*);
  bcmc_mem_model bcmc_mem_model_inst (.clk_i(clk_i), .go_i(go),
    .waits_i(waits), .bus_clock_o(bus_clock_i),
    .fast_core_clock_o(fast_core_clock_i), .bus_stall_n_o(bus_stall_n_i));
  always #12.5 clk_i = ~clk_i;
  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] got);
    checked++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog and read data monitor
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end else if (wb_ack_o === 1'b1 && !wb_we_i)
      check("read data", exp_q.pop_front(), wb_dat_o & msk_q.pop_front());
  end
  task automatic wb(input logic we, input logic [3:0] adr,
    input logic [31:0] dat, input logic [31:0] msk);
    if (!we) begin
      exp_q.push_back(dat & msk);
      msk_q.push_back(msk);
    end
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ticks(input int n);
    int t;
    t = 0;
    repeat (64) begin
      @(posedge clk_i);
      t += core_tick_o;
    end
    check("idle core ticks", n, t);
  endtask
  task automatic access(input logic rd, input logic bf, input int n);
    int ct, bt;
    logic seen;
    ct = 0;
    bt = 0;
    seen = 1'b0;
    @(posedge clk_i);
    waits <= 4'(n);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    while (bus_stall_n_i !== 1'b0) @(posedge clk_i);
    acc_req_i <= 1'b1;
    acc_read_i <= rd;
    acc_buffered_i <= bf;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    @(posedge clk_i);
    check("stall", rd | !bf, core_stall_o);
    check("mem req", 0, mem_req_n_o);
    do begin
      @(posedge clk_i);
      ct += core_tick_o;
      bt += bus_tick_o;
      seen |= core_on_bus_o;
    end while (acc_done_o !== 1'b1);
    check("mem req end", 1, mem_req_n_o);
    wsum += n;
    check("bus ticks", 1, bt);
    if (single_clock_sel_i)
      check("core ticks", n + 1, ct);
    else begin
      check("core on bus", rd | !bf, seen);
      repeat (sync_async_select_i ? 3 : 13) @(posedge clk_i);
      check("core back", 0, core_on_bus_o);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, `BCMC_ADR_STATUS, 32'h21, 32'h39);
    wb(1'b0, `BCMC_ADR_CTRL, 32'h1, 32'hFFFFFFFF);
    wb(1'b0, 4'hC, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, `BCMC_ADR_CTRL, 32'h3, 32'h0);
    repeat (4) begin
      r = $random(seed);
      access(r[4], r[5], 1 + r[1:0]);
    end
    wb(1'b0, `BCMC_ADR_WAITCNT, wsum, 32'hFFFF);
    addr_timing_sel_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("addr latch", 0, addr_latch_o);
    wb(1'b0, `BCMC_ADR_STATUS, 32'h1, 32'h21);
    single_clock_sel_i <= 1'b0;
    sync_async_select_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (24) @(posedge clk_i);
    check("addr latch", 1, addr_latch_o);
    ticks(8);
    wb(1'b1, `BCMC_ADR_CTRL, 32'h0, 32'h0);
    repeat (24) @(posedge clk_i);
    ticks(4);
    wb(1'b1, `BCMC_ADR_CTRL, 32'h1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sync_async_select_i <= !i[1];
      repeat (24) @(posedge clk_i);
      access(!i[0], 1'b1, 2);
    end
    stop_test();
  end
endmodule // bus_clock_mode_control_test
